// File: clock_reset_generator_defines.svh
`ifndef CLOCK_RESET_GENERATOR_DEFINES_SVH
`define CLOCK_RESET_GENERATOR_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ADDR_PLL_CTRL 8'h00
`define ADDR_ETH_GATE 8'h04
`define ADDR_MON_SEL 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_CFG_BASE 8'h40

// ==========================================================
// Field positions
`define PLL_M_LSB 0
`define PLL_N_LSB 8
`define PLL_OD_LSB 16
`define PLL_REF_BIT 24
`define PLL_BYP_BIT 25
`define CFG_SEL_LSB 0
`define CFG_PRE_LSB 4
`define ETH_RX_BIT 0
`define ETH_TX_BIT 1

// ==========================================================
// Reset values
`define PLL_M_RST 6'h01
`define PLL_N_RST 6'h01
`define PLL_OD_RST 2'h0
`define PLL_REF_RST 1'b1
`define PLL_BYP_RST 1'b1
`define CFG_PRE_RST 3'h0
`define MON_SEL_RST 5'h00

// ==========================================================
// Clock indices and source frequencies
`define CFG_COUNT 15
`define IDX_RTC 13
`define IDX_RNG 15
`define IDX_ETH_RX 16
`define IDX_ETH_TX 17
`define CLK_COUNT 18
`define RC_OSC_KHZ 8000
`define REF_MIN_KHZ 8000
`define REF_MAX_KHZ 24000
`define LOW_XTAL_HZ 32768

`endif

// File: clock_reset_generator_pkg.sv
package clock_reset_generator_pkg;

  // ==========================================================
  // Source of a generated clock
  typedef enum logic [1:0] {
    SRC_PLL = 2'h0,
    SRC_RC = 2'h1,
    SRC_EXT = 2'h2,
    SRC_LOW = 2'h3
  } clk_src_t;

  // Per-clock source select and prescaler
  typedef struct packed {
    logic [2:0] pre;
    clk_src_t sel;
  } clk_cfg_t;

  // PLL settings
  typedef struct packed {
    logic bypass;
    logic ref_rc;
    logic [1:0] od;
    logic [5:0] n;
    logic [5:0] m;
  } pll_cfg_t;

  // Post-divider code to divisor: 4^od[1] * 2^od[0]
  function automatic logic [3:0] od_divisor(input logic [1:0] od);
    od_divisor = 4'h1 << od;
  endfunction

  // Byte-lane merge for bus writes
  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    integer i;
    byte_merge = old_v;
    for (i = 0; i < 4; i = i + 1) begin
      if (sel[i]) begin
        byte_merge[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
  endfunction

endpackage

// File: pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic edge_o
);

  logic s0_reg;
  logic s1_reg;
  logic s2_reg;
  logic level_reg;
  logic edge_reg;

  // Change counts once second and third stages agree
  wire settle = (s1_reg == s2_reg) && (s2_reg != level_reg);

  // Three-stage capture, filtered level and one-cycle edge pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s0_reg <= 1'b0;
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      level_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else begin
      s0_reg <= pin_i;
      s1_reg <= s0_reg;
      s2_reg <= s1_reg;
      if (settle) begin
        level_reg <= s2_reg;
      end
      edge_reg <= settle;
    end
  end

  assign edge_o = edge_reg;

endmodule

// File: gen_clock.sv
`timescale 1ns/1ps
`include "clock_reset_generator_defines.svh"
module gen_clock #(
  parameter int PRE_W = 3,
  parameter logic [1:0] RESET_SEL = 2'h1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] src_tick_i,
  input wire clock_reset_generator_pkg::clk_cfg_t cfg_i,
  input wire logic run_i,
  output logic clk_o
);

  clock_reset_generator_pkg::clk_cfg_t act_reg;
  logic [6:0] cnt_reg;
  logic clk_reg;
  logic armed_reg;

  // Prescaler limited to the width this clock allows
  wire [2:0] pre_mask = 3'(( 4'h1 << PRE_W) - 4'h1);
  wire [2:0] pre_eff = act_reg.pre & pre_mask;
  wire [6:0] limit = 7'((8'h01 << pre_eff) - 8'h01);
  wire tick = src_tick_i[act_reg.sel];
  wire wrap = tick && (cnt_reg == limit);
  // New settings only taken with the output low at a phase start
  wire switch_ok = !clk_reg && (cnt_reg == 7'h00) && (cfg_i != act_reg);
  // Gate only ever holds the output low
  wire toggle = wrap && (run_i || clk_reg);

  // Divider, settings hand-over and output level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_reg <= '{pre: `CFG_PRE_RST,
                   sel: clock_reset_generator_pkg::clk_src_t'(RESET_SEL)};
      cnt_reg <= 7'h00;
      clk_reg <= 1'b0;
      armed_reg <= 1'b1;
    end else if (switch_ok) begin
      act_reg <= cfg_i;
      cnt_reg <= 7'h00;
      armed_reg <= 1'b0;
    end else if (!armed_reg) begin
      armed_reg <= tick; // First edge of the new source only sets the phase
    end else if (tick) begin
      cnt_reg <= wrap ? 7'h00 : cnt_reg + 7'h01;
      if (toggle) begin
        clk_reg <= ~clk_reg;
      end
    end
  end

  assign clk_o = clk_reg;

endmodule

// File: clock_reset_generator.sv
// Behaviour
// - The system clock can come from the external oscillator or the internal 8 MHz RC clock.
// - A 32.768 kHz low-speed crystal input is an extra source for the calendar clock.
// - The PLL takes an 8 to 24 MHz reference and has a bypass passing the reference through.
// - A register bit selects the PLL reference between external and RC oscillator.
// - PLL output equals reference times multiplier over input divider over post-divider.
// - Multiplier and input divider are unsigned 6-bit binary fields.
// - The 2-bit post-divider code divides by 4^upper times 2^lower, giving 1, 2, 4 or 8.
// - Each generated clock except the random-number and Ethernet clocks has its own select among PLL, RC and external clock.
// - System, serial and UART clocks each have a prescaler of 1, 2, 4 or 8.
// - Timer, PWM, calendar and watchdog clocks each divide by a power of two up to 128.
// - Eight PWM clocks, two timer clocks and the other named clocks are all provided.
// - The random-number clock runs only from the PLL output, with no select or prescaler.
// - The random-number clock stops by itself while the CPU sleeps.
// - The Ethernet receive and transmit pad clocks are each gated by a register bit.
// - Every produced clock can be chosen for the monitor output.
`timescale 1ns/1ps
`include "clock_reset_generator_defines.svh"
module clock_reset_generator (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_osc_clock_i,
  input wire logic rc_osc_clock_i,
  input wire logic low_xtal_clock_i,
  input wire logic eth_receive_clock_i,
  input wire logic eth_transmit_clock_i,
  input wire logic cpu_sleep_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic system_core_clock_o,
  output logic sync_serial_clock_o,
  output logic async_serial_clock_o,
  output logic timer_clock_a_o,
  output logic timer_clock_b_o,
  output logic [7:0] pulse_width_clocks_o,
  output logic calendar_clock_o,
  output logic watchdog_tick_clock_o,
  output logic random_source_clock_o,
  output logic eth_receive_clock_o,
  output logic eth_transmit_clock_o,
  output logic monitor_clock_o
);

  // ==========================================================
  // Source pin capture
  // One pulse per settled pin change
  logic ext_edge;
  logic rc_edge;
  logic low_edge;
  logic eth_rx_edge;
  logic eth_tx_edge;

  // External oscillator edges
  pin_sync u_sync_ext (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (ext_osc_clock_i),
    .edge_o (ext_edge)
  );

  // Internal RC oscillator edges
  pin_sync u_sync_rc (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (rc_osc_clock_i),
    .edge_o (rc_edge)
  );

  // Low-speed crystal edges
  pin_sync u_sync_low (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (low_xtal_clock_i),
    .edge_o (low_edge)
  );

  // Ethernet receive pad clock edges
  pin_sync u_sync_erx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (eth_receive_clock_i),
    .edge_o (eth_rx_edge)
  );

  // Ethernet transmit pad clock edges
  pin_sync u_sync_etx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (eth_transmit_clock_i),
    .edge_o (eth_tx_edge)
  );

  // ==========================================================
  // Register storage
  clock_reset_generator_pkg::pll_cfg_t pll_reg;
  clock_reset_generator_pkg::clk_cfg_t cfg_reg [`CFG_COUNT];

  // Gate enables and monitor index
  logic [1:0] eth_gate_reg;
  logic [4:0] mon_sel_reg;

  // Bus answer and monitor flops
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic mon_reg;

  // ==========================================================
  // PLL model
  // Credit count and output edge
  logic [12:0] credit_reg;
  logic pll_tick_reg;

  // Reference choice and divisor N * OD
  wire ref_edge = pll_reg.ref_rc ? rc_edge : ext_edge;
  wire [5:0] n_eff = (pll_reg.n == 6'h00) ? 6'h01 : pll_reg.n;
  wire [12:0] pll_div = 13'(n_eff)
                        * 13'(clock_reset_generator_pkg::od_divisor(pll_reg.od));
  wire [12:0] pll_add = ref_edge ? {7'h00, pll_reg.m} : 13'h0000;

  // One output edge once credit covers N*OD
  wire pll_emit = credit_reg >= pll_div;
  wire [12:0] pll_sub = pll_emit ? pll_div : 13'h0000;

  // Next credit, clipped so it cannot wind up
  wire [13:0] credit_sum = {1'b0, credit_reg} + {1'b0, pll_add} - {1'b0, pll_sub};
  wire credit_sat = credit_sum[13] || (credit_sum[12:0] > 13'h0fc0);

  // Credit accumulator: M credits per reference edge, N*OD per output edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      credit_reg <= 13'h0000;
      pll_tick_reg <= 1'b0;
    end else begin
      credit_reg <= credit_sat ? 13'h0fc0 : credit_sum[12:0];
      pll_tick_reg <= pll_reg.bypass ? ref_edge : pll_emit;
    end
  end

  // ==========================================================
  // Generated clocks with select and prescaler
  logic [`CLK_COUNT-1:0] clk_lvl;
  // Ticks in select order: PLL, RC, external, crystal
  wire [3:0] src_main = {1'b0, ext_edge, rc_edge, pll_tick_reg};
  wire [3:0] src_rtc = {low_edge, ext_edge, rc_edge, pll_tick_reg};

  // One generator per programmable clock
  genvar gi;
  generate
    for (gi = 0; gi < `CFG_COUNT; gi = gi + 1) begin : g_clk
      // System, serial and UART clocks take 2-bit prescalers
      gen_clock #(
        .PRE_W ((gi < 3) ? 2 : 3),
        .RESET_SEL (2'h1)
      ) u_clk (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .src_tick_i ((gi == `IDX_RTC) ? src_rtc : src_main),
        .cfg_i (cfg_reg[gi]),
        .run_i (1'b1),
        .clk_o (clk_lvl[gi])
      );
    end
  endgenerate

  // Random-number clock: PLL only, fixed divide, stopped in sleep
  gen_clock #(
    .PRE_W (1),
    .RESET_SEL (2'h0)
  ) u_rng (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .src_tick_i (src_main),
    .cfg_i ('{pre: 3'h0, sel: clock_reset_generator_pkg::SRC_PLL}),
    .run_i (!cpu_sleep_i),
    .clk_o (clk_lvl[`IDX_RNG])
  );

  // Ethernet receive clock gate
  gen_clock #(
    .PRE_W (1),
    .RESET_SEL (2'h0)
  ) u_eth_rx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .src_tick_i ({3'h0, eth_rx_edge}),
    .cfg_i ('{pre: 3'h0, sel: clock_reset_generator_pkg::SRC_PLL}),
    .run_i (eth_gate_reg[`ETH_RX_BIT]),
    .clk_o (clk_lvl[`IDX_ETH_RX])
  );

  // Ethernet transmit clock gate
  gen_clock #(
    .PRE_W (1),
    .RESET_SEL (2'h0)
  ) u_eth_tx (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .src_tick_i ({3'h0, eth_tx_edge}),
    .cfg_i ('{pre: 3'h0, sel: clock_reset_generator_pkg::SRC_PLL}),
    .run_i (eth_gate_reg[`ETH_TX_BIT]),
    .clk_o (clk_lvl[`IDX_ETH_TX])
  );

  // Clock outputs, each the flop inside its generator
  assign system_core_clock_o = clk_lvl[0];
  assign sync_serial_clock_o = clk_lvl[1];
  assign async_serial_clock_o = clk_lvl[2];

  // Timer, PWM, calendar and watchdog clocks
  assign timer_clock_a_o = clk_lvl[3];
  assign timer_clock_b_o = clk_lvl[4];
  assign pulse_width_clocks_o = clk_lvl[12:5];
  assign calendar_clock_o = clk_lvl[`IDX_RTC];
  assign watchdog_tick_clock_o = clk_lvl[14];

  // Fixed-source clocks
  assign random_source_clock_o = clk_lvl[`IDX_RNG];
  assign eth_receive_clock_o = clk_lvl[`IDX_ETH_RX];
  assign eth_transmit_clock_o = clk_lvl[`IDX_ETH_TX];

  // ==========================================================
  // Monitor output
  // Indices past the last clock read low
  wire mon_pick = (mon_sel_reg < 5'(`CLK_COUNT)) ? clk_lvl[mon_sel_reg] : 1'b0;

  // Registered monitor copy
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_reg <= 1'b0;
    end else begin
      mon_reg <= mon_pick;
    end
  end

  // Monitor pin from its flop
  assign monitor_clock_o = mon_reg;

  // ==========================================================
  // Wishbone decode
  wire bus_req = wb_cyc_i && wb_stb_i;
  wire wr_do = bus_req && wb_we_i && ack_reg;

  // Fixed register hits
  wire hit_pll = wb_adr_i == `ADDR_PLL_CTRL;
  wire hit_eth = wb_adr_i == `ADDR_ETH_GATE;
  wire hit_mon = wb_adr_i == `ADDR_MON_SEL;
  wire hit_stat = wb_adr_i == `ADDR_STATUS;

  // Per-clock window, one word each
  wire [5:0] cfg_off = wb_adr_i[7:2] - 6'(`ADDR_CFG_BASE >> 2);
  wire hit_cfg = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i >= `ADDR_CFG_BASE)
                 && (cfg_off < 6'(`CFG_COUNT));
  wire [3:0] cfg_idx = cfg_off[3:0];

  // Register images as read back
  wire [31:0] pll_word = ({31'h0, pll_reg.bypass} << `PLL_BYP_BIT)
                       | ({31'h0, pll_reg.ref_rc} << `PLL_REF_BIT)
                       | ({30'h0, pll_reg.od} << `PLL_OD_LSB)
                       | ({26'h0, pll_reg.n} << `PLL_N_LSB)
                       | ({26'h0, pll_reg.m} << `PLL_M_LSB);
  wire [31:0] cfg_word = ({29'h0, cfg_reg[cfg_idx].pre} << `CFG_PRE_LSB)
                       | ({30'h0, cfg_reg[cfg_idx].sel} << `CFG_SEL_LSB);

  // Write images with byte lanes merged
  wire [31:0] pll_new = clock_reset_generator_pkg::byte_merge(pll_word, wb_dat_i, wb_sel_i);
  wire [31:0] cfg_new = clock_reset_generator_pkg::byte_merge(cfg_word, wb_dat_i, wb_sel_i);

  // Read multiplexer, unmapped reads as zero
  wire [31:0] rd_mux = hit_pll ? pll_word
                     : hit_eth ? {30'h0, eth_gate_reg}
                     : hit_mon ? {27'h0, mon_sel_reg}
                     : hit_stat ? {14'h0, clk_lvl}
                     : hit_cfg ? cfg_word
                     : 32'h0000_0000;

  // Prescaler width of the addressed clock
  wire [2:0] pre_wr = (cfg_idx < 4'h3) ? {1'b0, cfg_new[`CFG_PRE_LSB +: 2]}
                                       : cfg_new[`CFG_PRE_LSB +: 3];

  // Acknowledge and read data, one wait state per access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Bus outputs from their flops
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // PLL, gate and monitor registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_reg <= '{bypass: `PLL_BYP_RST, ref_rc: `PLL_REF_RST, od: `PLL_OD_RST,
                   n: `PLL_N_RST, m: `PLL_M_RST};
      eth_gate_reg <= 2'h0;
      mon_sel_reg <= `MON_SEL_RST;
    end else if (wr_do) begin
      if (hit_pll) begin
        pll_reg.bypass <= pll_new[`PLL_BYP_BIT];
        pll_reg.ref_rc <= pll_new[`PLL_REF_BIT];
        pll_reg.od <= pll_new[`PLL_OD_LSB +: 2];
        pll_reg.n <= pll_new[`PLL_N_LSB +: 6];
        pll_reg.m <= pll_new[`PLL_M_LSB +: 6];
      end
      // Gate and monitor take the low byte
      if (hit_eth && wb_sel_i[0]) begin
        eth_gate_reg <= wb_dat_i[1:0];
      end
      if (hit_mon && wb_sel_i[0]) begin
        mon_sel_reg <= wb_dat_i[4:0];
      end
    end
  end

  // Per-clock select and prescaler registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `CFG_COUNT; i = i + 1) begin
        cfg_reg[i] <= '{pre: `CFG_PRE_RST, sel: clock_reset_generator_pkg::SRC_RC};
      end
    end else if (wr_do && hit_cfg) begin
      // Short prescalers keep the top bit clear
      cfg_reg[cfg_idx].pre <= pre_wr;
      cfg_reg[cfg_idx].sel <=
        clock_reset_generator_pkg::clk_src_t'(cfg_new[`CFG_SEL_LSB +: 2]);
    end
  end

endmodule

// File: clock_reset_generator_sva.sv
`timescale 1ns/1ps
`include "clock_reset_generator_defines.svh"
module clock_reset_generator_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cpu_sleep_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic system_core_clock_o,
  input wire logic sync_serial_clock_o,
  input wire logic async_serial_clock_o,
  input wire logic timer_clock_a_o,
  input wire logic timer_clock_b_o,
  input wire logic [7:0] pulse_width_clocks_o,
  input wire logic calendar_clock_o,
  input wire logic watchdog_tick_clock_o,
  input wire logic random_source_clock_o,
  input wire logic eth_receive_clock_o,
  input wire logic eth_transmit_clock_o,
  input wire logic monitor_clock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Snooped gate and monitor selects, and all clock levels
  logic [1:0] gate_reg;
  logic [4:0] mon_reg;
  logic [17:0] levels;
  logic wr_hit;
  logic mon_level;
  assign wr_hit = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign levels = {eth_transmit_clock_o, eth_receive_clock_o, random_source_clock_o,
    watchdog_tick_clock_o, calendar_clock_o, pulse_width_clocks_o, timer_clock_b_o,
    timer_clock_a_o, async_serial_clock_o, sync_serial_clock_o, system_core_clock_o};
  assign mon_level = (mon_reg < 5'h12) ? levels[mon_reg] : 1'b0;
  // Registers follow writes at the acknowledging edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_reg <= 2'h0;
      mon_reg <= 5'h00;
    end else if (wr_hit && wb_adr_i == `ADDR_ETH_GATE) begin
      gate_reg <= wb_dat_i[1:0];
    end else if (wr_hit && wb_adr_i == `ADDR_MON_SEL) begin
      mon_reg <= wb_dat_i[4:0];
    end
  end
  // ==========================================================
  // Bus answer
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i &&
    (wb_adr_i inside {[8'h10:8'h3f], [8'h7c:8'hff]}) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // ==========================================================
  // Clock gating, monitor and reset
  rng_sleep_stop_a: assert property (cpu_sleep_i [*3] ##0 !random_source_clock_o
    |=> !random_source_clock_o) else $error("random clock rose in sleep");
  rx_gate_stop_a: assert property (!gate_reg[0] [*3] ##0 !eth_receive_clock_o
    |=> !eth_receive_clock_o) else $error("gated receive clock rose");
  tx_gate_stop_a: assert property (!gate_reg[1] [*3] ##0 !eth_transmit_clock_o
    |=> !eth_transmit_clock_o) else $error("gated transmit clock rose");
  monitor_copy_a: assert property (monitor_clock_o == $past(mon_level))
    else $error("monitor not a copy of selected clock");
  rx_no_runt_a: assert property ($rose(eth_receive_clock_o) |=> eth_receive_clock_o)
    else $error("runt pulse on receive clock");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> levels == 18'h0 && !wb_ack_o
    && !monitor_clock_o) else $error("outputs active after reset edge");
endmodule

bind clock_reset_generator clock_reset_generator_sva chk (.clk_i(clk_i), .rst_i(rst_i),
  .cpu_sleep_i(cpu_sleep_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .system_core_clock_o(system_core_clock_o),
  .sync_serial_clock_o(sync_serial_clock_o), .async_serial_clock_o(async_serial_clock_o),
  .timer_clock_a_o(timer_clock_a_o), .timer_clock_b_o(timer_clock_b_o),
  .pulse_width_clocks_o(pulse_width_clocks_o), .calendar_clock_o(calendar_clock_o),
  .watchdog_tick_clock_o(watchdog_tick_clock_o), .random_source_clock_o(random_source_clock_o),
  .eth_receive_clock_o(eth_receive_clock_o), .eth_transmit_clock_o(eth_transmit_clock_o),
  .monitor_clock_o(monitor_clock_o));

// File: osc_model.sv
`timescale 1ns/1ps
// ==========================================================
// Free-running oscillators and pad clocks, unrelated in phase to clk_i
module osc_model #(
  parameter real EXT_H = 123.0,
  parameter real RC_H = 160.0,
  parameter real LOW_H = 1000.0,
  parameter real RX_H = 140.0,
  parameter real TX_H = 180.0
) (
  output logic ext_osc_clock_o,
  output logic rc_osc_clock_o,
  output logic low_xtal_clock_o,
  output logic eth_receive_clock_o,
  output logic eth_transmit_clock_o
);
  // Each source toggles every half period, scaled to stay trackable
  initial begin
    ext_osc_clock_o = 1'b0;
    forever #(EXT_H) ext_osc_clock_o = ~ext_osc_clock_o;
  end
  initial begin
    rc_osc_clock_o = 1'b0;
    forever #(RC_H) rc_osc_clock_o = ~rc_osc_clock_o;
  end
  // Low-speed crystal for the calendar clock
  initial begin
    low_xtal_clock_o = 1'b0;
    forever #(LOW_H) low_xtal_clock_o = ~low_xtal_clock_o;
  end
  initial begin
    eth_receive_clock_o = 1'b0;
    forever #(RX_H) eth_receive_clock_o = ~eth_receive_clock_o;
  end
  initial begin
    eth_transmit_clock_o = 1'b0;
    forever #(TX_H) eth_transmit_clock_o = ~eth_transmit_clock_o;
  end
endmodule

// File: tb.sv
`timescale 1ns/1ps
`include "clock_reset_generator_defines.svh"
module tb;
  localparam int WIN = 1024;
  localparam int SETTLE = 400;
  localparam real EXT_H = 123.0;
  localparam real RC_H = 160.0;
  localparam real LOW_H = 1000.0;
  localparam real RX_H = 140.0;
  localparam real TX_H = 180.0;
  logic clk, rst, sleep, cyc, stb, we, ack, mon, sys, sys_prev;
  logic ext_c, rc_c, low_c, rx_c, tx_c;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, rdat;
  logic [2:0] rp;
  logic [1:0] rs;
  int mismatches, checks_done, run_len;
  logic [31:0] exp_q[$];

  // ==========================================================
  // Design, sources and clock
  osc_model #(.EXT_H(EXT_H), .RC_H(RC_H), .LOW_H(LOW_H), .RX_H(RX_H), .TX_H(TX_H)) osc (
    .ext_osc_clock_o(ext_c), .rc_osc_clock_o(rc_c), .low_xtal_clock_o(low_c),
    .eth_receive_clock_o(rx_c), .eth_transmit_clock_o(tx_c));
  clock_reset_generator DUT (.clk_i(clk), .rst_i(rst), .ext_osc_clock_i(ext_c),
    .rc_osc_clock_i(rc_c), .low_xtal_clock_i(low_c), .eth_receive_clock_i(rx_c),
    .eth_transmit_clock_i(tx_c), .cpu_sleep_i(sleep), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .system_core_clock_o(sys), .sync_serial_clock_o(),
    .async_serial_clock_o(), .timer_clock_a_o(), .timer_clock_b_o(),
    .pulse_width_clocks_o(), .calendar_clock_o(), .watchdog_tick_clock_o(),
    .random_source_clock_o(), .eth_receive_clock_o(), .eth_transmit_clock_o(),
    .monitor_clock_o(mon));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Verdict and watchdog
  task automatic final_report();
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1800000;
    mismatches++;
    $display("MISMATCH %0t run did not finish", $time);
    final_report();
  end

  // ==========================================================
  // Read data checked against the oldest note at each read ack
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      checks_done++;
      if (exp_q.size() == 0 || rdat !== exp_q[0]) begin
        mismatches++;
        $display("MISMATCH %0t read %h got %h", $time, adr, rdat);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  // System clock phases never shorter than four cycles
  always @(posedge clk) begin
    if (!rst && sys !== sys_prev && run_len < 4) begin
      mismatches++;
      $display("MISMATCH %0t short system clock phase", $time);
    end
    run_len = (sys !== sys_prev) ? 1 : run_len + 1;
    sys_prev = sys;
  end

  // ==========================================================
  // Bus cycle, register and measurement helpers
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0, 4'hf);
  endtask
  task automatic cfg(input int i, input logic [2:0] p, input logic [1:0] s);
    bus(`ADDR_CFG_BASE + 8'(4 * i), 1'b1, {25'h0, p, 2'h0, s}, 4'hf);
  endtask
  // Count rising edges of the monitored clock over a window
  task automatic meas(input logic [4:0] idx, input real ev);
    int cnt;
    logic prev;
    cnt = 0;
    bus(`ADDR_MON_SEL, 1'b1, {27'h0, idx}, 4'hf);
    repeat (SETTLE) @(posedge clk);
    prev = mon;
    repeat (WIN) begin
      @(posedge clk);
      if (mon === 1'b1 && prev === 1'b0) cnt++;
      prev = mon;
    end
    checks_done++;
    if (real'(cnt) > ev + 2.0 || real'(cnt) < ev - 2.0) begin
      mismatches++;
      $display("MISMATCH %0t clock %0d rising %0d expected %0.1f", $time, idx, cnt, ev);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1; sleep = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'h0; dat = 32'h0;
    mismatches = 0; checks_done = 0; run_len = 100; sys_prev = 1'b0;
    void'($urandom(32'h424ce615));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_PLL_CTRL, 32'h0300_0101);
    rd(`ADDR_CFG_BASE, 32'h1);
    rd(`ADDR_ETH_GATE, 32'h0);
    rd(`ADDR_MON_SEL, 32'h0);
    bus(8'h30, 1'b1, 32'hffff_ffff, 4'hf);
    rd(8'h30, 32'h0);
    rd(8'h7c, 32'h0);
    bus(`ADDR_PLL_CTRL, 1'b1, 32'hffff_ff05, 4'h1);
    rd(`ADDR_PLL_CTRL, 32'h0300_0105);
    bus(`ADDR_CFG_BASE, 1'b1, 32'h72, 4'hf);
    rd(`ADDR_CFG_BASE, 32'h32);
    for (int i = 3; i < 15; i++) begin
      rp = 3'($urandom_range(7, 0));
      rs = 2'($urandom_range(2, 0));
      cfg(i, rp, rs);
      rd(`ADDR_CFG_BASE + 8'(4 * i), {25'h0, rp, 2'h0, rs});
    end
    for (int p = 0; p < 4; p++) begin
      cfg(0, 3'(p), 2'h1);
      meas(5'd0, WIN * 10.0 / RC_H / (1 << p));
    end
    cfg(0, 3'h0, 2'h2);
    meas(5'd0, WIN * 10.0 / EXT_H);
    cfg(2, 3'h0, 2'h3);
    meas(5'd2, 0.0);
    for (int i = 3; i < 15; i++) begin
      cfg(i, 3'(i % 8), 2'h2);
    end
    // Old random prescalers may hold a switch for two of their long phases
    repeat (2100) @(posedge clk);
    for (int i = 3; i < 15; i++) begin
      meas(5'(i), WIN * 10.0 / EXT_H / (1 << (i % 8)));
    end
    cfg(13, 3'h0, 2'h3);
    meas(5'd13, WIN * 10.0 / LOW_H);
    cfg(3, 3'h0, 2'h0);
    bus(`ADDR_PLL_CTRL, 1'b1, 32'h0300_0101, 4'hf);
    meas(5'd3, WIN * 10.0 / RC_H);
    bus(`ADDR_PLL_CTRL, 1'b1, 32'h0200_0101, 4'hf);
    meas(5'd3, WIN * 10.0 / EXT_H);
    for (int od = 0; od < 4; od++) begin
      bus(`ADDR_PLL_CTRL, 1'b1, 32'h0100_0104 | (32'(od) << 16), 4'hf);
      meas(5'd3, WIN * 40.0 / RC_H / (1 << od));
      meas(5'd15, WIN * 40.0 / RC_H / (1 << od));
    end
    bus(`ADDR_PLL_CTRL, 1'b1, 32'h0100_0203, 4'hf);
    meas(5'd3, WIN * 15.0 / RC_H);
    sleep <= 1'b1;
    meas(5'd15, 0.0);
    sleep <= 1'b0;
    meas(5'd16, 0.0);
    bus(`ADDR_ETH_GATE, 1'b1, 32'h3, 4'hf);
    meas(5'd16, WIN * 10.0 / RX_H);
    meas(5'd17, WIN * 10.0 / TX_H);
    bus(`ADDR_ETH_GATE, 1'b1, 32'h2, 4'h1);
    meas(5'd16, 0.0);
    meas(5'd20, 0.0);
    final_report();
  end
endmodule
